/* File: verilog/ipsc_pkg.sv */
// Shared constants and types for the idle and performance state coordinator.
// Assumes a single core clock domain; all users import the whole package.
`default_nettype none

package ipsc_pkg;

   // ----------------------------------------------------------------------
   // Idle levels, ordered so that a minimum picks the shallowest state.
   // ----------------------------------------------------------------------
   localparam int LVL_W = 3;
   localparam logic [LVL_W-1:0] LVL_C0 = 3'h0;
   localparam logic [LVL_W-1:0] LVL_C1 = 3'h1;
   localparam logic [LVL_W-1:0] LVL_C3 = 3'h2;
   localparam logic [LVL_W-1:0] LVL_C6 = 3'h3;
   localparam logic [LVL_W-1:0] LVL_C7 = 3'h4;
   // Report-only code; it never takes part in the minimum.
   localparam logic [LVL_W-1:0] LVL_EHALT = 3'h5;

   // ----------------------------------------------------------------------
   // Field widths.
   // ----------------------------------------------------------------------
   localparam int SUB_W = 4;
   localparam int RATIO_W = 8;
   localparam int VID_W = 8;
   localparam int IO_AW = 16;
   localparam int RANGE_W = 3;

   // Number of legacy idle-level addresses: deep levels C3, C6, C7.
   localparam logic [IO_AW-1:0] IO_LVL_COUNT = 16'h0003;

   // ----------------------------------------------------------------------
   // Voltage derivation and ramp timing.
   // ----------------------------------------------------------------------
   localparam logic [VID_W-1:0] VID_BASE = 8'h20;
   localparam logic [VID_W-1:0] VID_PER_CORE = 8'h02;
   localparam logic [RATIO_W-1:0] RESET_RATIO = 8'h08;
   localparam logic [VID_W-1:0] RESET_VID = 8'h28;
   localparam int CLK_MHZ = 40;
   localparam int RAMP_STEP_NS = 250;
   // Least time per voltage step, rounded up to whole cycles.
   localparam int RAMP_STEP_CYC = (RAMP_STEP_NS * CLK_MHZ + 999) / 1000;
   localparam int RAMP_CNT_W = 8;

   // ----------------------------------------------------------------------
   // Operating-point transition states.
   // ----------------------------------------------------------------------
   typedef enum logic [2:0]
   {
      PS_IDLE = 3'b001,
      PS_VRAMP = 3'b010,
      PS_LOCK = 3'b100
   } ipsc_ps_e;

endpackage

`default_nettype wire

/* File: verilog/ipsc_top.sv */
// Idle-state resolution, enhanced-halt reporting, legacy idle read trapping
// and shared operating-point sequencing for NC cores of two threads each.
// Assumes request, wake and software strobes come from logic on clk; only the
// synthesiser lock indication arrives from outside and is synchronised.
`timescale 1ns/1ps
`default_nettype none

// Contract
// [RL1] Resolved idle level of a thread pair is the lowest of its two levels.
// [RL2] With enhanced halt on and all cores C1 or deeper, C1 reports enhanced halt.
// [RL3] Power saving acts on the resolved core level, never on thread requests.
// [RL4] Threads and cores pass through C0 between two different idle states.
// [RL5] Without multithreading, the second thread is ignored; thread zero drives the core.
// [RL6] Software sets target frequency; voltage follows frequency and active core count.
// [RL7] One shared operating point, set by highest request among active cores.
// [RL8] Voltage settles first; synthesiser locks on the frequency afterwards.
// [RL9] Requests taken any time; a new one waits for the running transition.
// [RL10] Voltage ramps one step per timed interval to avoid glitches.
// [RL11] With redirection on, legacy idle reads become monitor-wait idle requests.
// [RL12] A redirected legacy read issues no system I/O read.
// [RL13] Firmware enables redirection before relying on legacy idle reads.
// [RL14] Only reads inside the programmed range trap; others pass as I/O reads.
// [RL15] Redirected idle requests carry sub-state zero.
// [RL16] Redirected idle requests wake on any interrupt, even when masked.
// [RL17] Wake on interrupt, monitored address access, or timed wait deadline.
// [RL18] Thread levels encoded C0, C1, C3, C6, C7 in ascending order.
module ipsc_top
#(
   parameter int NC = 2,
   parameter logic [ipsc_pkg::RATIO_W-1:0] INIT_RATIO = ipsc_pkg::RESET_RATIO,
   parameter logic [ipsc_pkg::VID_W-1:0] INIT_VID = ipsc_pkg::RESET_VID
)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic smt_en,
   input wire logic ehalt_en,
   input wire logic [2*NC-1:0] monitor_wait_request,
   input wire logic [2*NC-1:0][ipsc_pkg::LVL_W-1:0] mon_wait_level,
   input wire logic [2*NC-1:0][ipsc_pkg::SUB_W-1:0] mon_wait_substate,
   input wire logic [2*NC-1:0] mon_wait_timed,
   input wire logic [2*NC-1:0] mon_wait_break_masked,
   input wire logic [2*NC-1:0] halt_instruction,
   input wire logic [2*NC-1:0] intr,
   input wire logic [2*NC-1:0] interrupt_enable_flag,
   input wire logic [2*NC-1:0] monitor_hit,
   input wire logic [2*NC-1:0] deadline_expired,
   input wire logic io_redir_en,
   input wire logic [ipsc_pkg::IO_AW-1:0] io_trap_base,
   input wire logic [ipsc_pkg::RANGE_W-1:0] io_trap_range_config,
   input wire logic legacy_idle_level_read,
   input wire logic [$clog2(2*NC)-1:0] io_rd_tid,
   input wire logic [ipsc_pkg::IO_AW-1:0] io_rd_addr,
   input wire logic [NC-1:0] perf_wr,
   input wire logic [NC-1:0][ipsc_pkg::RATIO_W-1:0] perf_wr_ratio,
   input wire logic pll_locked,
   output logic [2*NC-1:0][ipsc_pkg::LVL_W-1:0] thread_level,
   output logic [2*NC-1:0][ipsc_pkg::SUB_W-1:0] thread_substate,
   output logic [NC-1:0][ipsc_pkg::LVL_W-1:0] core_level,
   output logic [NC-1:0][ipsc_pkg::LVL_W-1:0] core_report,
   output logic io_fwd_valid,
   output logic [ipsc_pkg::IO_AW-1:0] io_fwd_addr,
   output logic [ipsc_pkg::VID_W-1:0] vid_out,
   output logic [ipsc_pkg::RATIO_W-1:0] pll_ratio,
   output logic pll_req,
   output logic pstate_busy
);
   import ipsc_pkg::*;

   localparam int NT = 2 * NC;
   localparam int CNT_W = $clog2(NC + 1);

   // ----------------------------------------------------------------------
   // Legacy idle read decode.
   // ----------------------------------------------------------------------
   logic [IO_AW-1:0] io_off;
   logic io_hit;
   logic [LVL_W-1:0] io_lvl;
   logic io_fwd_valid_ff, nxt_io_fwd_valid;
   logic [IO_AW-1:0] io_fwd_addr_ff, nxt_io_fwd_addr;

   // The range field bounds the trapped window so firmware can keep some
   // levels on the bus; the level table itself bounds it too.
   always_comb
   begin
      io_off = io_rd_addr - io_trap_base;
      io_hit = legacy_idle_level_read && io_redir_en && (io_rd_addr >= io_trap_base) // [RL11] [RL13]
               && (io_off < {13'h0000, io_trap_range_config}) && (io_off < IO_LVL_COUNT); // [RL14]
      io_lvl = LVL_C3 + io_off[LVL_W-1:0];
      nxt_io_fwd_valid = legacy_idle_level_read && !io_hit; // [RL12] [RL14]
      nxt_io_fwd_addr = legacy_idle_level_read ? io_rd_addr : io_fwd_addr_ff;
   end

   // Registers the forwarded read so the system side sees clean data.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         io_fwd_valid_ff <= 1'b0;
         io_fwd_addr_ff <= 16'h0000;
      end
      else
      begin
         io_fwd_valid_ff <= nxt_io_fwd_valid;
         io_fwd_addr_ff <= nxt_io_fwd_addr;
      end
   end

   // ----------------------------------------------------------------------
   // Thread idle levels.
   // ----------------------------------------------------------------------
   logic [NT-1:0][LVL_W-1:0] thr_lvl_ff, nxt_thr_lvl;
   logic [NT-1:0][SUB_W-1:0] thr_sub_ff, nxt_thr_sub;
   logic [NT-1:0] thr_brk_ff, nxt_thr_brk;
   logic [NT-1:0] thr_mon_ff, nxt_thr_mon;
   logic [NT-1:0] thr_tmd_ff, nxt_thr_tmd;

   // A thread only accepts a new idle request while in C0, so leaving one
   // idle level always goes through the active state first.
   always_comb
   begin
      nxt_thr_lvl = thr_lvl_ff;
      nxt_thr_sub = thr_sub_ff;
      nxt_thr_brk = thr_brk_ff;
      nxt_thr_mon = thr_mon_ff;
      nxt_thr_tmd = thr_tmd_ff;
      for (int t = 0; t < NT; t++)
      begin
         if ((t % 2 == 1) && !smt_en)
         begin
            nxt_thr_lvl[t] = LVL_C0; // [RL5]
            nxt_thr_sub[t] = 4'h0;
            nxt_thr_brk[t] = 1'b0;
            nxt_thr_mon[t] = 1'b0;
            nxt_thr_tmd[t] = 1'b0;
         end
         else if (thr_lvl_ff[t] != LVL_C0)
         begin
            if ((intr[t] && (interrupt_enable_flag[t] || thr_brk_ff[t])) // [RL16] [RL17]
                || (monitor_hit[t] && thr_mon_ff[t]) || (deadline_expired[t] && thr_tmd_ff[t]))
            begin
               nxt_thr_lvl[t] = LVL_C0; // [RL4] [RL17]
               nxt_thr_sub[t] = 4'h0;
               nxt_thr_brk[t] = 1'b0;
               nxt_thr_mon[t] = 1'b0;
               nxt_thr_tmd[t] = 1'b0;
            end
         end
         else if (io_hit && (io_rd_tid == t[$clog2(NT)-1:0]))
         begin
            nxt_thr_lvl[t] = io_lvl; // [RL11]
            nxt_thr_sub[t] = 4'h0; // [RL15]
            nxt_thr_brk[t] = 1'b1; // [RL16]
            nxt_thr_mon[t] = 1'b0;
            nxt_thr_tmd[t] = 1'b0;
         end
         else if (monitor_wait_request[t] && (mon_wait_level[t] != LVL_C0) && (mon_wait_level[t] <= LVL_C7))
         begin
            nxt_thr_lvl[t] = mon_wait_level[t]; // [RL18]
            nxt_thr_sub[t] = mon_wait_substate[t];
            nxt_thr_brk[t] = mon_wait_break_masked[t];
            nxt_thr_mon[t] = 1'b1;
            nxt_thr_tmd[t] = mon_wait_timed[t];
         end
         else if (halt_instruction[t])
         begin
            nxt_thr_lvl[t] = LVL_C1;
            nxt_thr_sub[t] = 4'h0;
            nxt_thr_brk[t] = 1'b0;
            nxt_thr_mon[t] = 1'b0;
            nxt_thr_tmd[t] = 1'b0;
         end
      end
   end

   // Thread state registers.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         thr_lvl_ff <= '0;
         thr_sub_ff <= '0;
         thr_brk_ff <= '0;
         thr_mon_ff <= '0;
         thr_tmd_ff <= '0;
      end
      else
      begin
         thr_lvl_ff <= nxt_thr_lvl;
         thr_sub_ff <= nxt_thr_sub;
         thr_brk_ff <= nxt_thr_brk;
         thr_mon_ff <= nxt_thr_mon;
         thr_tmd_ff <= nxt_thr_tmd;
      end
   end

   // ----------------------------------------------------------------------
   // Idle-level resolution and reporting.
   // ----------------------------------------------------------------------
   logic [NC-1:0][LVL_W-1:0] core_ff, nxt_core;
   logic [NC-1:0][LVL_W-1:0] rpt_ff, nxt_rpt;
   logic [LVL_W-1:0] res;
   logic all_idle;

   // A core that would jump straight between two idle levels is held in C0
   // for one cycle; the cost is a cycle of latency on re-resolution.
   always_comb
   begin
      res = LVL_C0;
      all_idle = 1'b1;
      for (int c = 0; c < NC; c++)
      begin
         res = thr_lvl_ff[2*c];
         if (smt_en && (thr_lvl_ff[2*c+1] < res))
         begin
            res = thr_lvl_ff[2*c+1]; // [RL1] [RL5]
         end
         nxt_core[c] = res; // [RL3]
         if ((core_ff[c] != LVL_C0) && (res != LVL_C0) && (res != core_ff[c]))
         begin
            nxt_core[c] = LVL_C0; // [RL4]
         end
         if (nxt_core[c] == LVL_C0)
         begin
            all_idle = 1'b0;
         end
      end
      for (int c = 0; c < NC; c++)
      begin
         nxt_rpt[c] = (ehalt_en && all_idle && (nxt_core[c] == LVL_C1)) ? LVL_EHALT : nxt_core[c]; // [RL2]
      end
   end

   // Resolved-level registers.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         core_ff <= '0;
         rpt_ff <= '0;
      end
      else
      begin
         core_ff <= nxt_core;
         rpt_ff <= nxt_rpt;
      end
   end

   // ----------------------------------------------------------------------
   // Shared operating point.
   // ----------------------------------------------------------------------
   logic [NC-1:0][RATIO_W-1:0] req_ff, nxt_req;
   logic [RATIO_W-1:0] tgt_ratio;
   logic [CNT_W-1:0] act_cnt;
   logic [VID_W-1:0] tgt_vid;
   ipsc_ps_e ps_ff, nxt_ps;
   logic [VID_W-1:0] vid_ff, nxt_vid, pend_vid_ff, nxt_pend_vid;
   logic [RATIO_W-1:0] ratio_ff, nxt_ratio, pend_ratio_ff, nxt_pend_ratio;
   logic pll_req_ff, nxt_pll_req;
   logic [RAMP_CNT_W-1:0] ramp_cnt_ff, nxt_ramp_cnt;
   logic ramp_tick;
   logic lock_m_ff, lock_s_ff, lock_q_ff;

   // Requests are stored whenever written, so a busy sequencer simply picks
   // up the latest value once it returns to idle.
   always_comb
   begin
      nxt_req = req_ff;
      tgt_ratio = 8'h00;
      act_cnt = '0;
      for (int c = 0; c < NC; c++)
      begin
         if (perf_wr[c])
         begin
            nxt_req[c] = perf_wr_ratio[c]; // [RL6] [RL9]
         end
         if (core_ff[c] <= LVL_C1)
         begin
            act_cnt = act_cnt + 1'b1;
            if (req_ff[c] > tgt_ratio)
            begin
               tgt_ratio = req_ff[c]; // [RL7]
            end
         end
      end
      if (act_cnt == '0)
      begin
         tgt_ratio = ratio_ff;
      end
      tgt_vid = VID_BASE + {1'b0, tgt_ratio[RATIO_W-1:1]} + VID_W'(act_cnt * VID_PER_CORE); // [RL6]
      ramp_tick = (ramp_cnt_ff == RAMP_CNT_W'(RAMP_STEP_CYC - 1));
      nxt_ramp_cnt = (ramp_tick || (ps_ff != PS_VRAMP)) ? 8'h00 : ramp_cnt_ff + 8'h01;
      nxt_ps = ps_ff;
      nxt_vid = vid_ff;
      nxt_ratio = ratio_ff;
      nxt_pend_vid = pend_vid_ff;
      nxt_pend_ratio = pend_ratio_ff;
      nxt_pll_req = 1'b0;
      unique case (ps_ff)
         PS_IDLE:
         begin
            if ((tgt_ratio != ratio_ff) || (tgt_vid != vid_ff))
            begin
               nxt_pend_ratio = tgt_ratio; // [RL9]
               nxt_pend_vid = tgt_vid;
               nxt_ps = PS_VRAMP;
            end
         end
         PS_VRAMP:
         begin
            if (vid_ff == pend_vid_ff)
            begin
               nxt_ratio = pend_ratio_ff; // [RL8]
               nxt_pll_req = 1'b1;
               nxt_ps = PS_LOCK;
            end
            else if (ramp_tick)
            begin
               nxt_vid = (vid_ff < pend_vid_ff) ? vid_ff + 8'h01 : vid_ff - 8'h01; // [RL10]
            end
         end
         PS_LOCK:
         begin
            if (lock_s_ff && !lock_q_ff)
            begin
               nxt_ps = PS_IDLE; // [RL9]
            end
         end
         default:
         begin
            nxt_ps = PS_IDLE;
         end
      endcase
   end

   // Operating-point registers; the lock input crosses in by two flops.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         req_ff <= {NC{INIT_RATIO}};
         ps_ff <= PS_IDLE;
         vid_ff <= INIT_VID;
         ratio_ff <= INIT_RATIO;
         pend_vid_ff <= INIT_VID;
         pend_ratio_ff <= INIT_RATIO;
         pll_req_ff <= 1'b0;
         ramp_cnt_ff <= 8'h00;
         lock_m_ff <= 1'b0;
         lock_s_ff <= 1'b0;
         lock_q_ff <= 1'b0;
      end
      else
      begin
         req_ff <= nxt_req;
         ps_ff <= nxt_ps;
         vid_ff <= nxt_vid;
         ratio_ff <= nxt_ratio;
         pend_vid_ff <= nxt_pend_vid;
         pend_ratio_ff <= nxt_pend_ratio;
         pll_req_ff <= nxt_pll_req;
         ramp_cnt_ff <= nxt_ramp_cnt;
         lock_m_ff <= pll_locked;
         lock_s_ff <= lock_m_ff;
         lock_q_ff <= lock_s_ff;
      end
   end

   assign thread_level = thr_lvl_ff;
   assign thread_substate = thr_sub_ff;
   assign core_level = core_ff;
   assign core_report = rpt_ff;
   assign io_fwd_valid = io_fwd_valid_ff;
   assign io_fwd_addr = io_fwd_addr_ff;
   assign vid_out = vid_ff;
   assign pll_ratio = ratio_ff;
   assign pll_req = pll_req_ff;
   assign pstate_busy = (ps_ff != PS_IDLE);

endmodule // ipsc_top

`default_nettype wire

/* File: bench/ipsc_top_sva.sv */
// Checker for ipsc_top: idle resolution, legacy read trapping, operating-point steps.
// Assumes one clock domain and at least two cores; bound to every ipsc_top.
`timescale 1ns/1ps
`default_nettype none
module ipsc_chk
#(
   parameter int NC = 2
)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic smt_en,
   input wire logic ehalt_en,
   input wire logic io_redir_en,
   input wire logic [ipsc_pkg::IO_AW-1:0] io_trap_base,
   input wire logic [ipsc_pkg::RANGE_W-1:0] io_trap_range_config,
   input wire logic legacy_idle_level_read,
   input wire logic [$clog2(2*NC)-1:0] io_rd_tid,
   input wire logic [ipsc_pkg::IO_AW-1:0] io_rd_addr,
   input wire logic [2*NC-1:0][ipsc_pkg::LVL_W-1:0] thread_level,
   input wire logic [2*NC-1:0][ipsc_pkg::SUB_W-1:0] thread_substate,
   input wire logic [NC-1:0][ipsc_pkg::LVL_W-1:0] core_level,
   input wire logic [NC-1:0][ipsc_pkg::LVL_W-1:0] core_report,
   input wire logic io_fwd_valid,
   input wire logic [ipsc_pkg::IO_AW-1:0] io_fwd_addr,
   input wire logic [ipsc_pkg::VID_W-1:0] vid_out,
   input wire logic [ipsc_pkg::RATIO_W-1:0] pll_ratio,
   input wire logic pll_req,
   input wire logic pstate_busy
);
   import ipsc_pkg::*;
   // ---------------------------------------------------------------
   // Properties. The core may show a C0 bubble, so only "not deeper" is safe.
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   property p_core_min;
      1 |=> core_level[0] <= $past(thread_level[0]) && (!$past(smt_en) || core_level[0] <= $past(thread_level[1]));
   endproperty
   a_core_min: assert property (p_core_min)
      else $error("Resolved level deeper than a counted thread.");
   property p_report;
      1 |-> core_report[0] == (($past(ehalt_en) && core_level[0] == LVL_C1 && core_level[1] != LVL_C0) ? LVL_EHALT
         : core_level[0]);
   endproperty
   a_report: assert property (p_report)
      else $error("Reported idle level wrong.");
   property p_core_c0;
      $changed(core_level[0]) && core_level[0] != LVL_C0 |-> $past(core_level[0]) == LVL_C0;
   endproperty
   a_core_c0: assert property (p_core_c0)
      else $error("Resolved level changed idle state without C0.");
   property p_thr_c0;
      $changed(thread_level[0]) && thread_level[0] != LVL_C0 |-> $past(thread_level[0]) == LVL_C0;
   endproperty
   a_thr_c0: assert property (p_thr_c0)
      else $error("Thread changed idle state without C0.");
   property p_trap;
      legacy_idle_level_read && io_redir_en && io_rd_addr == io_trap_base && io_trap_range_config != 3'h0
         && io_rd_tid == 0 && thread_level[0] == LVL_C0
      |=> thread_level[0] == LVL_C3 && thread_substate[0] == 4'h0 && !io_fwd_valid;
   endproperty
   a_trap: assert property (p_trap)
      else $error("Trapped read not turned into idle request.");
   property p_fwd;
      legacy_idle_level_read && !io_redir_en |=> io_fwd_valid && io_fwd_addr == $past(io_rd_addr);
   endproperty
   a_fwd: assert property (p_fwd)
      else $error("Untrapped read not forwarded.");
   property p_volt_first;
      $changed(pll_ratio) |-> pll_req && pstate_busy && $stable(vid_out);
   endproperty
   a_volt_first: assert property (p_volt_first)
      else $error("Frequency changed before voltage settled.");
   property p_ramp;
      $changed(vid_out) |-> (vid_out == $past(vid_out) + 8'h01 || vid_out + 8'h01 == $past(vid_out))
         ##1 $stable(vid_out) [*8];
   endproperty
   a_ramp: assert property (p_ramp)
      else $error("Voltage stepped too far or too fast.");
   property p_req_pulse;
      pll_req |=> !pll_req;
   endproperty
   a_req_pulse: assert property (p_req_pulse)
      else $error("Lock request longer than one cycle.");
   c_ehalt: cover property (core_report[0] == LVL_EHALT);
   c_trap: cover property (legacy_idle_level_read && io_redir_en ##1 thread_level[0] != LVL_C0);
   c_req: cover property (pll_req);
endmodule // ipsc_chk
bind ipsc_top ipsc_chk #(.NC(NC)) u_chk (.clk, .arst_n, .smt_en, .ehalt_en, .io_redir_en, .io_trap_base,
   .io_trap_range_config, .legacy_idle_level_read, .io_rd_tid, .io_rd_addr, .thread_level, .thread_substate,
   .core_level, .core_report, .io_fwd_valid, .io_fwd_addr, .vid_out, .pll_ratio, .pll_req, .pstate_busy);
`default_nettype wire

/* File: bench/ipsc_top_test.sv */
// Bench for ipsc_top: thread requests, legacy reads and ratio writes with checks.
// Assumes the checker is bound; the bench itself answers the synthesiser lock.
`timescale 1ns/1ps
`default_nettype none
module ipsc_top_test;
   import ipsc_pkg::*;
   localparam logic [15:0] BASE = 16'h0410;
   logic clk = 1'b0, arst_n = 1'b0, smt_en = 1'b1, io_redir_en = 1'b0, legacy_idle_level_read = 1'b0;
   logic pll_locked = 1'b0, ehalt_en = 1'b1, trap, io_fwd_valid, pll_req, pstate_busy;
   logic [3:0] monitor_wait_request = '0, mon_wait_timed = '0, intr = '0, interrupt_enable_flag = '1;
   logic [3:0] monitor_hit = '0, deadline_expired = '0, halt_instruction = '0, lk = '0;
   logic [3:0][2:0] mon_wait_level = '0, thread_level;
   logic [3:0][3:0] mon_wait_substate = '0, thread_substate;
   logic [1:0] io_rd_tid = '0, perf_wr = '0;
   logic [1:0][7:0] perf_wr_ratio = '0;
   logic [1:0][2:0] core_level, core_report;
   logic [15:0] io_rd_addr = '0, io_fwd_addr;
   logic [7:0] vid_out, pll_ratio;
   int errors = 0, n_checks = 0, nfwd = 0, f0;
   ipsc_top uut (.clk, .arst_n, .smt_en, .ehalt_en, .monitor_wait_request, .mon_wait_level, .mon_wait_substate,
      .mon_wait_timed, .mon_wait_break_masked(4'h0), .halt_instruction, .intr, .interrupt_enable_flag,
      .monitor_hit, .deadline_expired, .io_redir_en, .io_trap_base(BASE), .io_trap_range_config(3'h2),
      .legacy_idle_level_read, .io_rd_tid, .io_rd_addr, .perf_wr, .perf_wr_ratio, .pll_locked, .thread_level,
      .thread_substate, .core_level, .core_report, .io_fwd_valid, .io_fwd_addr, .vid_out, .pll_ratio, .pll_req,
      .pstate_busy);
   // Clock; lock rises a few cycles after each request and falls before the next one that needs a voltage step can come.
   always #12.5 clk = ~clk;
   always @(posedge clk)
   begin
      lk <= (pll_req === 1'b1) ? 4'hc : ((lk != 4'h0) ? lk - 4'h1 : 4'h0);
      pll_locked <= lk != 4'h0 && lk < 4'h8;
      if (io_fwd_valid === 1'b1) nfwd <= nfwd + 1;
   end
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic settle();
      repeat (4) @(posedge clk);
      #1;
   endtask
   task automatic mw(input int t, input logic [2:0] l, input logic tm);
      @(posedge clk);
      monitor_wait_request[t] <= 1'b1;
      mon_wait_level[t] <= l;
      mon_wait_substate[t] <= 4'h7;
      mon_wait_timed[t] <= tm;
      @(posedge clk);
      monitor_wait_request[t] <= 1'b0;
   endtask
   // Wake kinds: 0 interrupt, 1 monitor hit, 2 deadline, 3 halt entry.
   task automatic wk(input int k, input logic [3:0] m);
      @(posedge clk);
      case (k)
         0: intr <= m;
         1: monitor_hit <= m;
         2: deadline_expired <= m;
         default: halt_instruction <= m;
      endcase
      @(posedge clk);
      {intr, monitor_hit, deadline_expired, halt_instruction} <= '0;
   endtask
   task automatic lr(input logic [15:0] a);
      f0 = nfwd;
      @(posedge clk);
      legacy_idle_level_read <= 1'b1;
      io_rd_addr <= a;
      @(posedge clk);
      legacy_idle_level_read <= 1'b0;
      settle();
   endtask
   task automatic pw(input int c, input logic [7:0] r);
      @(posedge clk);
      perf_wr[c] <= 1'b1;
      perf_wr_ratio[c] <= r;
      @(posedge clk);
      perf_wr[c] <= 1'b0;
   endtask
   // Waits for the lock request, checks the new point, then waits for idle.
   task automatic pwait(input logic [7:0] er, input logic [7:0] ev);
      int n;
      for (n = 0; n < 400 && pll_req !== 1'b1; n++) @(posedge clk) #1;
      chk("pll_req", 16'(pll_req), 16'h0001);
      chk("pll_ratio", 16'(pll_ratio), 16'(er));
      chk("vid_out", 16'(vid_out), 16'(ev));
      for (n = 0; n < 40 && pstate_busy !== 1'b0; n++) @(posedge clk) #1;
   endtask
   task automatic finish_test();
      $display("Checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Watchdog, far beyond the several hundred cycles the sequence needs.
   initial
   begin
      repeat (30000) @(posedge clk);
      errors++;
      finish_test();
   end
   // ---------------------------------------------------------------
   // Main sequence.
   // ---------------------------------------------------------------
   initial
   begin
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      #1;
      chk("vid_rst", 16'(vid_out), 16'h0028);
      chk("ratio_rst", 16'(pll_ratio), 16'h0008);
      for (int a = 0; a < 4; a++)
         for (int b = 0; b < 4; b++)
         begin
            mw(0, LVL_C1 + 3'(a), 1'b0);
            mw(1, LVL_C1 + 3'(b), 1'b0);
            settle();
            chk("thread", 16'(thread_level[0]), 16'(LVL_C1 + 3'(a)));
            chk("core", 16'(core_level[0]), 16'(LVL_C1 + 3'(a < b ? a : b)));
            chk("report", 16'(core_report[0]), 16'(LVL_C1 + 3'(a < b ? a : b)));
            wk(0, 4'h3);
            settle();
            chk("woken", 16'(core_level[0]), 16'(LVL_C0));
         end
      mw(2, LVL_C3, 1'b0);
      mw(3, LVL_C6, 1'b0);
      mw(0, LVL_C1, 1'b0);
      mw(1, LVL_C7, 1'b0);
      settle();
      chk("ehalt", 16'(core_report[0]), 16'(LVL_EHALT));
      @(posedge clk) ehalt_en <= 1'b0;
      settle();
      chk("ehalt_off", 16'(core_report[0]), 16'(LVL_C1));
      @(posedge clk) ehalt_en <= 1'b1;
      wk(0, 4'hf);
      mw(0, LVL_C6, 1'b0);
      mw(1, LVL_C1, 1'b0);
      @(posedge clk) smt_en <= 1'b0;
      settle();
      chk("smt_core", 16'(core_level[0]), 16'(LVL_C6));
      mw(1, LVL_C3, 1'b0);
      settle();
      chk("smt_odd", 16'(thread_level[1]), 16'(LVL_C0));
      @(posedge clk) smt_en <= 1'b1;
      wk(0, 4'hf);
      for (int k = 0; k < 3; k++)
      begin
         mw(0, LVL_C3, 1'(k == 2));
         wk(k, 4'h1);
         settle();
         chk("wake", 16'(thread_level[0]), 16'(LVL_C0));
      end
      @(posedge clk) interrupt_enable_flag <= 4'h0;
      wk(3, 4'h2);
      wk(0, 4'h2);
      settle();
      chk("halt_masked", 16'(thread_level[1]), 16'(LVL_C1));
      lr(BASE);
      chk("redir_off", 16'(nfwd - f0), 16'h0001);
      @(posedge clk) io_redir_en <= 1'b1;
      for (int off = -1; off < 3; off++)
      begin
         trap = off >= 0 && off < 2;
         lr(BASE + 16'(off));
         chk("trap_lvl", 16'(thread_level[0]), trap ? 16'(LVL_C3 + 3'(off)) : 16'(LVL_C0));
         chk("trap_fwd", 16'(nfwd - f0), trap ? 16'h0000 : 16'h0001);
         chk("trap_sub", 16'(thread_substate[0]), 16'h0000);
         if (!trap) chk("fwd_addr", io_fwd_addr, BASE + 16'(off));
         wk(0, 4'h1);
         settle();
         chk("any_irq", 16'(thread_level[0]), 16'(LVL_C0));
      end
      @(posedge clk) interrupt_enable_flag <= 4'hf;
      wk(0, 4'h2);
      // Idling both threads of the first pair lowers the active count, and with it the voltage target.
      mw(0, LVL_C3, 1'b0);
      mw(1, LVL_C3, 1'b0);
      pwait(8'h08, 8'h26);
      wk(0, 4'h3);
      pwait(8'h08, 8'h28);
      pw(0, 8'h0a);
      pw(1, 8'h10);
      #1;
      chk("busy", 16'(pstate_busy), 16'h0001);
      pwait(8'h0a, 8'h29);
      pwait(8'h10, 8'h2c);
      pw(1, 8'h06);
      pwait(8'h0a, 8'h29);
      mw(2, LVL_C6, 1'b0);
      settle();
      chk("thread_only", 16'(pstate_busy), 16'h0000);
      mw(3, LVL_C6, 1'b0);
      pwait(8'h0a, 8'h27);
      finish_test();
   end
endmodule // ipsc_top_test
`default_nettype wire
